// ==== design/bpc_regs.vh ====
`ifndef BPC_REGS_VH
`define BPC_REGS_VH
// Pulse-mode breakpoint length in CPU clocks
`define BPC_PULSE_CYCLES 4'h8
// Low code space bounds served by the external-access select
`define BPC_LOW_CODE_LO 16'h0000
`define BPC_LOW_CODE_HI 16'h3fff
// CPU clock rate select codes
`define BPC_SPD_12 2'h0
`define BPC_SPD_24 2'h1
`define BPC_SPD_48 2'h2
// Reset values
`define BPC_SPD_RESET 2'h0
`define BPC_CFG_RESET 2'h0
// Field positions in the cpu and port control words
`define BPC_CPU_TRI_BIT 1
`define BPC_PA0_ALT_BIT 0
`define BPC_PA1_ALT_BIT 1
`endif

// ==== design/bpc_irq_pin.v ====
`timescale 1ns/1ps
`include "bpc_regs.vh"
// One Port A pin with its alternate external interrupt function.
module bpc_irq_pin (
   input wire ref_clk,
   input wire reset,
   input wire pin_in,
   input wire gpio_out,
   input wire gpio_oe,
   input wire alt_sel,
   input wire trigger_type,
   input wire irq_ack,
   output reg pin_out,
   output reg pin_oe,
   output reg pin_val,
   output reg irq_req
);
   reg sync1_q;
   reg sync2_q;
   reg prev_q;
   wire fall;

   assign fall = prev_q & ~sync2_q;

   always @(posedge ref_clk) begin
      if (reset) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
         prev_q <= 1'b1;
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
         pin_val <= 1'b1;
         irq_req <= 1'b0;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
         pin_val <= sync2_q;
         pin_out <= gpio_out;
         // Interrupt function takes the pin as input only
         pin_oe <= gpio_oe & ~alt_sel;
         if (!alt_sel) begin
            irq_req <= 1'b0;
         end else if (trigger_type) begin
            // Latched edge; a new edge wins over the acknowledge
            if (fall) begin
               irq_req <= 1'b1;
            end else if (irq_ack) begin
               irq_req <= 1'b0;
            end
         end else begin
            irq_req <= ~sync2_q;
         end
      end
   end
endmodule

// ==== design/bpc_top.v ====
`timescale 1ns/1ps
`include "bpc_regs.vh"
module bpc_top (
   input wire ref_clk,
   input wire reset_n,
   input wire [15:0] cpu_addr,
   input wire code_fetch,
   input wire [7:0] break_addr_hi,
   input wire [7:0] break_addr_lo,
   input wire break_enable_bit,
   input wire break_pulse_mode_bit,
   input wire break_flag_clear,
   input wire external_code_select,
   input wire [1:0] cpu_speed_sel,
   input wire [1:0] cpu_control_reg,
   input wire [1:0] port_a_alt_function_reg,
   input wire irq0_trigger_type,
   input wire irq1_trigger_type,
   input wire irq0_ack,
   input wire irq1_ack,
   input wire [1:0] port_a_gpio_out,
   input wire [1:0] port_a_gpio_oe,
   input wire port_a_pin0_in,
   input wire port_a_pin1_in,
   output reg break_match_out,
   output reg break_flag,
   output reg fetch_external,
   output reg cpu_clock_out,
   output reg cpu_clock_out_oe,
   output reg [1:0] cpu_speed,
   output wire port_a_pin0_out,
   output wire port_a_pin0_oe,
   output wire port_a_pin1_out,
   output wire port_a_pin1_oe,
   output wire [1:0] port_a_pin_val,
   output reg ext_irq0_n,
   output reg ext_irq1_n
);
   reg rst_s1_q;
   reg rst_s2_q;
   reg ea_s1_q;
   reg ea_s2_q;
   reg [3:0] pulse_cnt_q;
   reg [1:0] div_q;
   reg en_half_q;
   reg en_quarter_q;
   reg [1:0] cfg_q;
   reg tri_q;
   wire reset;
   wire hit;
   wire irq0_req;
   wire irq1_req;

   function in_low_code;
      input [15:0] a;
      begin
         in_low_code = (a >= `BPC_LOW_CODE_LO) && (a <= `BPC_LOW_CODE_HI);
      end
   endfunction

   // Chip reset pin is asynchronous to ref_clk, so it is synchronised.
   // Costs two edges: outputs take their reset values on the third edge.
   always @(posedge ref_clk) begin
      rst_s1_q <= ~reset_n;
      rst_s2_q <= rst_s1_q;
   end
   assign reset = rst_s2_q;

   assign hit = break_enable_bit &&
                (cpu_addr == {break_addr_hi, break_addr_lo});

   // External-access pin is sampled through two flops before use
   always @(posedge ref_clk) begin
      if (reset) begin
         ea_s1_q <= 1'b0;
         ea_s2_q <= 1'b0;
         fetch_external <= 1'b0;
      end else begin
         ea_s1_q <= external_code_select;
         ea_s2_q <= ea_s1_q;
         // Above 16 KB code always comes from outside
         fetch_external <= code_fetch &
            (ea_s2_q | ~in_low_code(cpu_addr));
      end
   end

   // Counter holds the high cycles still owed after the match edge
   always @(posedge ref_clk) begin
      if (reset) begin
         break_match_out <= 1'b0;
         break_flag <= 1'b0;
         pulse_cnt_q <= 4'h0;
      end else begin
         if (break_pulse_mode_bit) begin
            // Pulse mode keeps no flag, so a software clear has no effect
            break_flag <= 1'b0;
            if (hit) begin
               pulse_cnt_q <= `BPC_PULSE_CYCLES - 4'h1;
               break_match_out <= 1'b1;
            end else if (pulse_cnt_q != 4'h0) begin
               pulse_cnt_q <= pulse_cnt_q - 4'h1;
            end else begin
               break_match_out <= 1'b0;
            end
         end else begin
            pulse_cnt_q <= 4'h0;
            // A new match wins over the software clear
            if (hit) begin
               break_flag <= 1'b1;
               break_match_out <= 1'b1;
            end else if (break_flag_clear) begin
               break_flag <= 1'b0;
               break_match_out <= 1'b0;
            end
         end
      end
   end

   // Clock output: ref_clk stands in for the PLL CPU clock; slower rates
   // are divided, so cpu_clock_out toggles every 1, 2 or 4 ref_clk cycles (ref_clk/2, /4 or /8).
   always @(posedge ref_clk) begin
      if (reset) begin
         cpu_speed <= `BPC_SPD_RESET;
         tri_q <= 1'b0;
         cpu_clock_out_oe <= 1'b1;
         cfg_q <= `BPC_CFG_RESET;
      end else begin
         cpu_speed <= (cpu_speed_sel == 2'h3) ? `BPC_SPD_48 : cpu_speed_sel;
         tri_q <= cpu_control_reg[`BPC_CPU_TRI_BIT];
         cpu_clock_out_oe <= ~tri_q;
         cfg_q <= port_a_alt_function_reg;
      end
   end

   // Divider enables are one-cycle pulses, so only ref_clk clocks flops
   always @(posedge ref_clk) begin
      if (reset) begin
         div_q <= 2'h0;
         en_half_q <= 1'b0;
         en_quarter_q <= 1'b0;
      end else begin
         div_q <= div_q + 2'h1;
         en_half_q <= ~div_q[0];
         en_quarter_q <= (div_q == 2'h2);
      end
   end

   always @(posedge ref_clk) begin
      if (reset) begin
         cpu_clock_out <= 1'b0;
      end else begin
         case (cpu_speed)
            `BPC_SPD_48: cpu_clock_out <= ~cpu_clock_out;
            `BPC_SPD_24: begin
               if (en_half_q) begin
                  cpu_clock_out <= ~cpu_clock_out;
               end
            end
            default: begin
               if (en_quarter_q) begin
                  cpu_clock_out <= ~cpu_clock_out;
               end
            end
         endcase
      end
   end

   bpc_irq_pin u_pin0 (
      .ref_clk(ref_clk),
      .reset(reset),
      .pin_in(port_a_pin0_in),
      .gpio_out(port_a_gpio_out[0]),
      .gpio_oe(port_a_gpio_oe[0]),
      .alt_sel(cfg_q[`BPC_PA0_ALT_BIT]),
      .trigger_type(irq0_trigger_type),
      .irq_ack(irq0_ack),
      .pin_out(port_a_pin0_out),
      .pin_oe(port_a_pin0_oe),
      .pin_val(port_a_pin_val[0]),
      .irq_req(irq0_req)
   );

   bpc_irq_pin u_pin1 (
      .ref_clk(ref_clk),
      .reset(reset),
      .pin_in(port_a_pin1_in),
      .gpio_out(port_a_gpio_out[1]),
      .gpio_oe(port_a_gpio_oe[1]),
      .alt_sel(cfg_q[`BPC_PA1_ALT_BIT]),
      .trigger_type(irq1_trigger_type),
      .irq_ack(irq1_ack),
      .pin_out(port_a_pin1_out),
      .pin_oe(port_a_pin1_oe),
      .pin_val(port_a_pin_val[1]),
      .irq_req(irq1_req)
   );

   // Registered so the processor sees a clean active-low level
   always @(posedge ref_clk) begin
      if (reset) begin
         ext_irq0_n <= 1'b1;
         ext_irq1_n <= 1'b1;
      end else begin
         ext_irq0_n <= ~irq0_req;
         ext_irq1_n <= ~irq1_req;
      end
   end
endmodule

// ==== verif/bpc_irq_src.sv ====
`timescale 1ns/1ps
module bpc_irq_src (
   input wire port_a_pin0_out,
   input wire port_a_pin0_oe,
   input wire port_a_pin1_out,
   input wire port_a_pin1_oe,
   input wire [1:0] src_low,
   output wire port_a_pin0_in,
   output wire port_a_pin1_in
);
   // Released lines sit on the board pull-up unless a source sinks them
   assign port_a_pin0_in = port_a_pin0_oe ? port_a_pin0_out
      : !src_low[0];
   assign port_a_pin1_in = port_a_pin1_oe ? port_a_pin1_out
      : !src_low[1];
endmodule

// ==== verif/bpc_top_checker.sv ====
`timescale 1ns/1ps
module bpc_top_checker (
   input wire ref_clk,
   input wire reset_n,
   input wire [15:0] cpu_addr,
   input wire [7:0] break_addr_hi,
   input wire [7:0] break_addr_lo,
   input wire break_enable_bit,
   input wire break_pulse_mode_bit,
   input wire break_flag_clear,
   input wire [1:0] cpu_control_reg,
   input wire [1:0] port_a_alt_function_reg,
   input wire irq0_trigger_type,
   input wire port_a_pin0_in,
   input wire break_match_out,
   input wire break_flag,
   input wire cpu_clock_out_oe,
   input wire [1:0] cpu_speed,
   input wire port_a_pin1_oe,
   input wire ext_irq0_n
);
   wire hit = break_enable_bit && cpu_addr == {break_addr_hi, break_addr_lo};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   property p_hit; hit |=> break_match_out; endproperty
   a_hit: assert property (p_hit) else $error("no break");
   property p_pls; $rose(break_match_out) && break_pulse_mode_bit |->
      break_match_out [*8] ##1 !break_match_out; endproperty
   a_pls: assert property (p_pls) else $error("pulse length");
   property p_hold; break_flag && !break_pulse_mode_bit && !break_flag_clear
      |=> break_flag && break_match_out; endproperty
   a_hold: assert property (p_hold) else $error("flag lost");
   property p_clr; break_flag_clear && !hit && !break_pulse_mode_bit
      |=> !break_flag; endproperty
   a_clr: assert property (p_clr) else $error("flag kept");
   property p_rst; disable iff (1'h0) !reset_n [*3] |=> !break_match_out &&
      !break_flag && cpu_speed == 2'h0; endproperty
   a_rst: assert property (p_rst) else $error("reset");
   property p_tri; $stable(cpu_control_reg[1]) |=>
      cpu_clock_out_oe != $past(cpu_control_reg[1]); endproperty
   a_tri: assert property (p_tri) else $error("clock drive");
   property p_irq; port_a_alt_function_reg[0] && irq0_trigger_type &&
      $fell(port_a_pin0_in) |-> ##[3:4] !ext_irq0_n; endproperty
   a_irq: assert property (p_irq) else $error("edge irq");
   property p_alt; port_a_alt_function_reg[1] [*2] |=> !port_a_pin1_oe;
   endproperty
   a_alt: assert property (p_alt) else $error("pin drive");
endmodule
bind bpc_top bpc_top_checker u_chk (.*);

// ==== verif/bpc_top_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %0t %h", $time, a); end end
module bpc_top_tb;
   reg ref_clk = 1'h0, reset_n = 1'h0, code_fetch = 1'h0, irq0_ack = 1'h0;
   reg break_enable_bit = 1'h1, break_pulse_mode_bit = 1'h1, last;
   reg break_flag_clear = 1'h0, external_code_select = 1'h0, irq1_ack = 1'h0;
   reg irq0_trigger_type = 1'h1, irq1_trigger_type = 1'h0;
   reg [15:0] cpu_addr = 16'h0000;
   reg [7:0] break_addr_hi = 8'h12, break_addr_lo = 8'h34;
   reg [1:0] cpu_speed_sel = 2'h0, cpu_control_reg = 2'h0, src_low = 2'h0;
   reg [1:0] port_a_alt_function_reg = 2'h0, port_a_gpio_out = 2'h1;
   reg [1:0] port_a_gpio_oe = 2'h3;
   wire break_match_out, break_flag, fetch_external, cpu_clock_out;
   wire cpu_clock_out_oe, port_a_pin0_out, port_a_pin0_oe, port_a_pin1_out;
   wire port_a_pin1_oe, ext_irq0_n, ext_irq1_n, port_a_pin0_in;
   wire port_a_pin1_in;
   wire [1:0] cpu_speed, port_a_pin_val;
   int checks = 0, n_mismatch = 0, n, i, s;
   bpc_top u_bpc_top (.*);
   bpc_irq_src u_bpc_irq_src (.*);
   always #50 ref_clk = ~ref_clk;
   task cyc(input int k);
      repeat (k) @(negedge ref_clk);
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      cyc(16);
      reset_n = 1'h1;
      cyc(3);
      `CHK(cpu_speed, 2'h0)
      cpu_addr = 16'h1234;
      n = 0;
      for (i = 0; i < 12; i++) begin
         cyc(1);
         n += break_match_out;
         // A near miss must not restart the pulse
         cpu_addr = 16'h1235;
      end
      `CHK(n, 8)
      $display("test 1 done");
      break_pulse_mode_bit = 1'h0;
      cpu_addr = 16'h1234;
      break_flag_clear = 1'h1;
      cyc(1);
      break_flag_clear = 1'h0;
      cpu_addr = 16'h0000;
      cyc(9);
      `CHK(break_flag, 1'h1)
      `CHK(break_match_out, 1'h1)
      break_flag_clear = 1'h1;
      cyc(1);
      break_flag_clear = 1'h0;
      break_enable_bit = 1'h0;
      cpu_addr = 16'h1234;
      cyc(3);
      `CHK(break_match_out, 1'h0)
      $display("test 2 done");
      code_fetch = 1'h1;
      for (i = 0; i < 2; i++) begin
         external_code_select = i[0];
         cyc(4);
         `CHK(fetch_external, i[0])
      end
      for (s = 0; s < 3; s++) begin
         cpu_speed_sel = s[1:0];
         cyc(4);
         `CHK(cpu_speed, s[1:0])
         n = 0;
         for (i = 0; i < 16; i++) begin
            last = cpu_clock_out;
            cyc(1);
            n += (cpu_clock_out !== last);
         end
         `CHK(n, 4 << s)
      end
      cpu_control_reg = 2'h2;
      cyc(3);
      `CHK(cpu_clock_out_oe, 1'h0)
      cpu_control_reg = 2'h0;
      $display("test 3 done");
      port_a_alt_function_reg = 2'h3;
      cyc(3);
      `CHK(port_a_pin0_oe, 1'h0)
      src_low = 2'h1;
      cyc(6);
      `CHK(ext_irq0_n, 1'h0)
      src_low = 2'h2;
      cyc(5);
      `CHK(ext_irq1_n, 1'h0)
      src_low = 2'h0;
      irq0_ack = 1'h1;
      irq1_ack = 1'h1;
      cyc(1);
      irq0_ack = 1'h0;
      irq1_ack = 1'h0;
      cyc(4);
      `CHK({ext_irq1_n, ext_irq0_n}, 2'h3)
      port_a_alt_function_reg = 2'h0;
      cyc(3);
      `CHK(port_a_pin0_oe, 1'h1)
      cyc(3);
      `CHK({port_a_pin1_out, port_a_pin0_out, port_a_pin_val}, 4'h5)
      $display("test 4 done");
      break_enable_bit = 1'h1;
      reset_n = 1'h0;
      cyc(3);
      `CHK({break_match_out, break_flag, cpu_speed, port_a_pin1_oe}, 5'h00)
      reset_n = 1'h1;
      $display("test 5 done");
      conclude;
   end
endmodule
